// [see_ctl_model.sv]
// Bus controller model: drives SCL and pulls SDA low, paced by mclk.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
module see_ctl_model (
  input wire logic mclk, // system clock, paces the bus
  input wire logic sda, // resolved data wire
  output logic scl, // serial clock
  output logic pull // high while pulling SDA low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Clock low 5 cycles, high 3 (160 ns): target answers 4 cycles after a fall
  task automatic bit_io(input logic b, output logic r);
    tk(2);
    pull = ~b;
    tk(3);
    scl = 1'b1;
    r = sda;
    tk(3);
    scl = 1'b0;
  endtask

  // One-cycle spike on SCL while it is low; the target must not count it
  task automatic spike;
    tk(2);
    scl = 1'b1;
    tk(1);
    scl = 1'b0;
  endtask

  task automatic start;
    tk(3);
    pull = 1'b0;
    tk(3);
    scl = 1'b1;
    tk(5);
    pull = 1'b1;
    tk(5);
    scl = 1'b0;
  endtask

  // Clock then stands high until the next frame
  task automatic stop;
    tk(3);
    pull = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(5);
    pull = 1'b0;
    tk(8);
  endtask

  // Eight data bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
  endtask
endmodule

// [see_eeprom_slave.sv]
// Two-wire serial EEPROM target: bus decode, page buffer, programming and array.
// Assumes SCL and SDA arrive from pins, open-drain SDA resolved outside the module.
module see_eeprom_slave
  import see_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
  input wire logic mclk, // system clock, 50 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value, always low
  output logic sda_oe, // high while pulling SDA low
  input wire logic chip_select_strap_2, // device select strap, bit 2
  input wire logic chip_select_strap_1, // device select strap, bit 1
  input wire logic chip_select_strap_0, // device select strap, bit 0
  input wire logic write_protect, // high blocks programming
  output logic standby, // high in standby
  output logic programming // high during the self-timed write
);

  // ----------------------------------------------------------------
  // Pin synchronisers and glitch filter
  // ----------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [1:0] sync2_d;
  logic [1:0] clean_q;
  logic [1:0] clean;

  assign pin_raw = {write_protect, chip_select_strap_2, chip_select_strap_1,
                    chip_select_strap_0, sda_in, scl_in};

  generate
    for (genvar i = 0; i < 6; i++) begin : g_sync
      // Pins reset to their idle levels so release gives no false edge
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          sync1[i] <= (i < 2) ? 1'b1 : 1'b0;
          sync2[i] <= (i < 2) ? 1'b1 : 1'b0;
        end else begin
          sync1[i] <= pin_raw[i];
          sync2[i] <= sync1[i];
        end
      end
      if (i < 2) begin : g_filt
        // A level must be seen on two samples before it counts
        always_comb begin
          clean[i] = (sync2[i] == sync2_d[i]) ? sync2[i] : clean_q[i];
        end
        always_ff @(posedge mclk) begin
          if (sys_rst) begin
            sync2_d[i] <= 1'b1;
            clean_q[i] <= 1'b1;
          end else begin
            sync2_d[i] <= sync2[i];
            clean_q[i] <= clean[i];
          end
        end
      end
    end
  endgenerate

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [2:0] strap;
  logic wp;

  assign scl_rise = clean[0] & ~clean_q[0];
  assign scl_fall = ~clean[0] & clean_q[0];
  assign bus_start = clean[0] & clean_q[0] & clean_q[1] & ~clean[1];
  assign bus_stop = clean[0] & clean_q[0] & ~clean_q[1] & clean[1];
  // Open straps need an external or pad pull-down to read as low
  assign strap = sync2[4:2];
  assign wp = sync2[5];

  // ----------------------------------------------------------------
  // Bus state, address counter, page buffer and programming
  // ----------------------------------------------------------------
  see_state_t state;
  see_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic mack;
  logic next_mack;
  logic [ADDR_W-1:0] addr_cnt;
  logic [ADDR_W-1:0] next_addr;
  logic [PAGE_BYTES-1:0] pvalid;
  logic [PAGE_BYTES-1:0] next_pvalid;
  logic next_oe;
  logic [5:0] cidx;
  logic [5:0] next_cidx;
  logic [5:0] cidx_dec;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic buf_we;
  logic load_byte;
  logic fifo_valid;
  logic [7:0] fifo_head;
  logic [TIMER_W-1:0] write_last;

  assign write_last = TIMER_W'(WRITE_CYCLES - 1);
  assign cidx_dec = cidx - 6'h01;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_rx = rx;
    next_tx = tx;
    next_mack = mack;
    next_addr = addr_cnt;
    next_pvalid = pvalid;
    next_oe = sda_oe;
    next_cidx = cidx;
    next_timer = timer;
    buf_we = 1'b0;
    load_byte = 1'b0;
    if (state == ST_BUSY) begin
      // Pins are not even looked at until the write time has run out
      if (cidx != COMMIT_END) begin
        next_cidx = cidx + 6'h01;
      end
      next_timer = timer + TIMER_W'(1);
      if (timer == write_last) begin
        next_state = ST_IDLE;
        next_pvalid = PVALID_RST;
      end
    end else if (bus_start) begin
      // A repeated START drops any unsent page data, keeping the counter
      next_state = ST_DEVADDR;
      next_bitcnt = BIT_ARM;
      next_oe = 1'b0;
      next_pvalid = PVALID_RST;
    end else if (bus_stop) begin
      next_bitcnt = 4'h0;
      next_oe = 1'b0;
      next_state = ST_IDLE;
      if (state == ST_WDATA && pvalid != PVALID_RST && !wp) begin
        next_state = ST_BUSY;
        next_cidx = 6'h00;
        next_timer = '0;
      end
    end else if (state == ST_IDLE || state == ST_IGNORE) begin
      next_oe = 1'b0;
    end else if (scl_rise) begin
      if (bitcnt < BIT_ACK) begin
        next_rx = {rx[6:0], clean[1]};
      end else begin
        next_mack = ~clean[1];
      end
    end else if (scl_fall) begin
      if (bitcnt < BIT_LAST) begin
        next_bitcnt = bitcnt + 4'h1;
        if (state == ST_RDATA) begin
          next_tx = {tx[6:0], 1'b1};
          next_oe = ~tx[6];
        end
      end else if (bitcnt == BIT_LAST) begin
        next_bitcnt = BIT_ACK;
        next_oe = 1'b1;
        case (state)
          ST_DEVADDR: begin
            if (rx[PRE_MSB:PRE_LSB] != DEV_PREAMBLE ||
                rx[SEL_MSB:SEL_LSB] != strap) begin
              next_oe = 1'b0;
              next_state = ST_IDLE;
            end
          end
          ST_ADDR_HI: begin
            next_addr = {rx[ADDR_W-9:0], addr_cnt[7:0]};
          end
          ST_ADDR_LO: begin
            next_addr = {addr_cnt[ADDR_W-1:8], rx};
          end
          ST_WDATA: begin
            // Writing a byte over its old value is the erase, no extra step
            buf_we = 1'b1;
            next_pvalid[addr_cnt[PAGE_OFS_W-1:0]] = 1'b1;
            next_addr = {addr_cnt[ADDR_W-1:PAGE_OFS_W],
                         addr_cnt[PAGE_OFS_W-1:0] + 5'h01};
          end
          default: begin
            next_oe = 1'b0;
          end
        endcase
      end else if (bitcnt == BIT_ACK) begin
        next_bitcnt = 4'h0;
        next_oe = 1'b0;
        case (state)
          ST_DEVADDR: begin
            if (rx[RW_BIT]) begin
              next_state = ST_RDATA;
              load_byte = 1'b1;
            end else begin
              next_state = ST_ADDR_HI;
            end
          end
          ST_ADDR_HI: next_state = ST_ADDR_LO;
          ST_ADDR_LO: next_state = ST_WDATA;
          ST_RDATA: begin
            if (mack) begin
              load_byte = 1'b1;
            end else begin
              next_state = ST_IGNORE;
            end
          end
          default: begin
            next_state = state;
          end
        endcase
      end else begin
        // First fall after START only arms the bit counter
        next_bitcnt = 4'h0;
      end
    end
    if (load_byte) begin
      next_tx = fifo_valid ? fifo_head : BYTE_RST;
      next_oe = ~next_tx[7];
      next_addr = addr_cnt + 13'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      rx <= 8'h00;
      tx <= BYTE_RST;
      mack <= 1'b0;
      addr_cnt <= ADDR_RST;
      pvalid <= PVALID_RST;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      cidx <= 6'h00;
      timer <= '0;
      standby <= 1'b1;
      programming <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      rx <= next_rx;
      tx <= next_tx;
      mack <= next_mack;
      addr_cnt <= next_addr;
      pvalid <= next_pvalid;
      sda_oe <= next_oe;
      sda_out <= 1'b0;
      cidx <= next_cidx;
      timer <= next_timer;
      standby <= (next_state == ST_IDLE);
      programming <= (next_state == ST_BUSY);
    end
  end

  // ----------------------------------------------------------------
  // Memories: array and page buffer
  // ----------------------------------------------------------------
  logic arr_we;
  logic [ADDR_W-1:0] arr_addr;
  logic [7:0] arr_rd;
  logic [PAGE_OFS_W-1:0] buf_addr;
  logic [7:0] buf_rd;
  logic [ADDR_W-1:0] pf_addr;

  // Buffer word k is read at cidx k and lands in the array at cidx k+1
  assign arr_we = (state == ST_BUSY) && (cidx != 6'h00) && (cidx <= COMMIT_LAST) &&
                  pvalid[cidx_dec[PAGE_OFS_W-1:0]];
  assign arr_addr = (state == ST_BUSY) ?
                    {addr_cnt[ADDR_W-1:PAGE_OFS_W], cidx_dec[PAGE_OFS_W-1:0]} : pf_addr;
  assign buf_addr = (state == ST_BUSY) ? cidx[PAGE_OFS_W-1:0] : addr_cnt[PAGE_OFS_W-1:0];

  see_ram #(.DW(DATA_W), .AW(ADDR_W)) u_array (
    .mclk(mclk),
    .we(arr_we),
    .addr(arr_addr),
    .wdata(buf_rd),
    .rdata(arr_rd)
  );

  see_ram #(.DW(DATA_W), .AW(PAGE_OFS_W)) u_page (
    .mclk(mclk),
    .we(buf_we),
    .addr(buf_addr),
    .wdata(rx),
    .rdata(buf_rd)
  );

  // ----------------------------------------------------------------
  // Read prefetch through a two-entry buffer
  // ----------------------------------------------------------------
  // Prefetch hides the array latency from the short SCL low phase; the
  // buffer is flushed whenever the counter may move other than by a read.
  logic [7:0] fifo_d0;
  logic [7:0] fifo_d1;
  logic [7:0] next_d0;
  logic [7:0] next_d1;
  logic [1:0] fifo_cnt;
  logic [1:0] next_fifo_cnt;
  logic [1:0] cnt_after;
  logic rd_inflight;
  logic next_inflight;
  logic [ADDR_W-1:0] next_pf_addr;
  logic flush;
  logic fifo_in_ready;
  logic issue;
  logic push;
  logic pop;

  assign flush = !(state == ST_DEVADDR || state == ST_RDATA);
  assign fifo_in_ready = (fifo_cnt != 2'h2);
  assign issue = !flush && !rd_inflight && fifo_in_ready;
  assign push = rd_inflight && !flush;
  assign fifo_valid = (fifo_cnt != 2'h0);
  assign fifo_head = fifo_d0;
  assign pop = load_byte && fifo_valid;

  always_comb begin
    next_d0 = fifo_d0;
    next_d1 = fifo_d1;
    cnt_after = fifo_cnt - {1'b0, pop};
    if (pop) begin
      next_d0 = fifo_d1;
    end
    if (push) begin
      if (cnt_after == 2'h0) begin
        next_d0 = arr_rd;
      end else begin
        next_d1 = arr_rd;
      end
    end
    next_fifo_cnt = flush ? 2'h0 : cnt_after + {1'b0, push};
    next_inflight = issue;
    next_pf_addr = flush ? addr_cnt : (issue ? pf_addr + 13'h0001 : pf_addr);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fifo_d0 <= BYTE_RST;
      fifo_d1 <= BYTE_RST;
      fifo_cnt <= 2'h0;
      rd_inflight <= 1'b0;
      pf_addr <= ADDR_RST;
    end else begin
      fifo_d0 <= next_d0;
      fifo_d1 <= next_d1;
      fifo_cnt <= next_fifo_cnt;
      rd_inflight <= next_inflight;
      pf_addr <= next_pf_addr;
    end
  end

endmodule

// [see_eeprom_slave_sva.sv]
// Pin-level checks for the two-wire EEPROM target.
// Assumes SCL stays low >= 5 and high >= 3 system clocks.
module see_chk #(
  parameter int WRITE_CYCLES = 250000
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // resolved data wire
  input wire logic sda_out, // data drive value
  input wire logic sda_oe, // data pull enable
  input wire logic write_protect, // programming block
  input wire logic standby, // idle status
  input wire logic programming // write cycle status
);
  logic [17:0] busy_cnt;
  logic [17:0] next_busy_cnt;

  // Length of the current write cycle
  always_comb begin
    next_busy_cnt = programming ? busy_cnt + 18'h00001 : 18'h00000;
  end

  always_ff @(posedge mclk) begin
    busy_cnt <= sys_rst ? 18'h00000 : next_busy_cnt;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_bus_idle;
    scl_in && sda_in;
  endsequence

  a_out_low: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_reset_idle: assert property (disable iff (1'b0)
    sys_rst |=> standby && !programming && !sda_oe)
    else $error("outputs not idle after reset");
  a_busy_no_ack: assert property (programming |-> !sda_oe)
    else $error("response while programming");
  a_busy_not_sby: assert property (programming |-> !standby)
    else $error("standby during programming");
  a_write_time: assert property ($fell(programming) |->
    busy_cnt != 18'h00000 && int'(busy_cnt) <= WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_done_standby: assert property ($fell(programming) |-> ##[0:1] standby)
    else $error("no standby after programming");
  a_ack_on_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 3))
    else $error("data pulled outside clock low");
  a_oe_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive changed with clock high");
  a_wp_blocks: assert property ($rose(programming) |-> !write_protect)
    else $error("programming while protected");
  a_prog_on_stop: assert property ($rose(programming) |-> s_bus_idle)
    else $error("programming without stop");
endmodule

bind see_eeprom_slave see_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .mclk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe,
  .write_protect, .standby, .programming
);

// [see_eeprom_slave_tb.sv]
// Self-checking bench for the two-wire EEPROM target.
// Assumes the controller model and a pull-up on the data wire.
module see_eeprom_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WCYC = 200;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic wp = 1'b0;
  logic scl;
  logic pull;
  logic sda_oe;
  logic standby;
  logic programming;
  logic [8:0] rx;
  wire sda = ~(sda_oe | pull);
  int n_mismatch = 0;
  int n_checks = 0;

  always #10 mclk = ~mclk;

  see_eeprom_slave #(.WRITE_CYCLES(WCYC)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .chip_select_strap_2(strap[2]),
    .chip_select_strap_1(strap[1]), .chip_select_strap_0(strap[0]),
    .write_protect(wp), .standby(standby), .programming(programming)
  );

  see_ctl_model u_ctl (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic ack);
    u_ctl.xfer({b, 1'b1}, rx);
    chk({7'h00, rx[0]}, {7'h00, ~ack});
  endtask

  task automatic wait_done;
    int k;
    k = 0;
    while (programming !== 1'b0 && k < 1000) begin
      @(posedge mclk);
      k++;
    end
    #1;
    chk({7'h00, programming}, 8'h00);
    if (k >= 1000) begin
      give_verdict();
    end
  endtask

  task automatic head(input logic [12:0] a);
    u_ctl.start();
    send({4'hA, strap, 1'b0}, 1'b1);
    send({3'h0, a[12:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask

  task automatic wr(input logic [12:0] a, input int n, input logic [7:0] d0);
    head(a);
    for (int i = 0; i < n; i++) begin
      send(d0 + 8'(i), 1'b1);
    end
    u_ctl.stop();
  endtask

  // Word address load, repeated start, then a streamed read
  task automatic rd(input logic [12:0] a, input int n, input logic [7:0] e0);
    head(a);
    u_ctl.start();
    send({4'hA, strap, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_ctl.xfer({8'hFF, i == n - 1}, rx);
      chk(rx[8:1], e0 + 8'(i));
    end
    u_ctl.stop();
  endtask

  task automatic t_byte_poll;
    wr(13'h1FFF, 1, 8'h5A);
    chk({6'h00, standby, programming}, 8'h01);
    u_ctl.start();
    send({4'hA, strap, 1'b0}, 1'b0);
    u_ctl.stop();
    wait_done();
    chk({7'h00, standby}, 8'h01);
    wr(13'h0000, 1, 8'h5B);
    wait_done();
    rd(13'h1FFF, 2, 8'h5A);
  endtask

  task automatic t_select;
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      u_ctl.start();
      send({4'hB, strap, 1'b0}, 1'b0);
      u_ctl.start();
      send({4'hA, ~strap, 1'b0}, 1'b0);
      u_ctl.start();
      send({4'hA, strap, 1'b0}, 1'b1);
      u_ctl.spike();
      send(8'h00, 1'b1);
      u_ctl.stop();
    end
    strap = 3'h0;
  endtask

  // 34 bytes from offset 30: the last two overwrite offsets 30 and 31
  task automatic t_page;
    wr(13'h0A5E, 34, 8'h40);
    wait_done();
    rd(13'h0A40, 32, 8'h42);
  endtask

  task automatic t_protect;
    wp = 1'b1;
    wr(13'h0A40, 1, 8'h00);
    chk({6'h00, standby, programming}, 8'h02);
    rd(13'h0A40, 1, 8'h42);
    wp = 1'b0;
    head(13'h0A40);
    send(8'h00, 1'b1);
    u_ctl.start();
    u_ctl.stop();
    chk({7'h00, programming}, 8'h00);
    rd(13'h0A40, 1, 8'h42);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk({5'h00, standby, programming, sda_oe}, 8'h04);
    $display("test reset end");
    t_byte_poll();
    $display("test byte write end");
    t_select();
    $display("test select end");
    t_page();
    $display("test page end");
    t_protect();
    $display("test protect end");
    give_verdict();
  end
endmodule

// [see_pkg.sv]
// Constants and types shared by the two-wire EEPROM target logic.
// Assumes a single 50 MHz system clock; all pin timing is derived from it.
package see_pkg;

  // ----------------------------------------------------------------
  // Array organisation
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int PAGE_OFS_W = 5;
  localparam int PAGE_COUNT = 256;
  localparam int PAGE_BYTES = 32;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Device address byte
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_PREAMBLE = 4'hA;
  localparam int PRE_MSB = 7;
  localparam int PRE_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;

  // ----------------------------------------------------------------
  // Bit counter marks within one nine-clock word
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ARM = 4'hF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_TIME_MS = 5;
  // Longest time, so round down
  localparam int WRITE_CYCLES_DFLT = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 18;
  localparam logic [5:0] COMMIT_END = 6'h21;
  localparam logic [5:0] COMMIT_LAST = 6'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_RST = 13'h0000;
  localparam logic [31:0] PVALID_RST = 32'h0000_0000;
  localparam logic [7:0] BYTE_RST = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_ADDR_HI = 3'h3,
    ST_ADDR_LO = 3'h2,
    ST_WDATA   = 3'h6,
    ST_RDATA   = 3'h7,
    ST_BUSY    = 3'h5,
    ST_IGNORE  = 3'h4
  } see_state_t;

endpackage

// [see_ram.sv]
// Single-port synchronous memory with registered read data.
// Assumes one access per clock; a write returns the old word on rdata.
module see_ram #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  input wire logic mclk, // system clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] addr, // word address
  input wire logic [DW-1:0] wdata, // write data
  output logic [DW-1:0] rdata // registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
